// ### deac_ctrl.sv
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module deac_ctrl
    import deac_pkg::*;
#(
    parameter int WRITE_CYC = DEAC_WRITE_CYC,
    parameter int PWRUP_CYC = DEAC_PWRUP_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        por_n,
    input  wire logic        protect,
    input  wire logic        prog_req,
    input  wire logic [7:0]  prog_addr,
    output logic             prog_valid,
    output logic [7:0]       prog_data,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////
    // Storage and state

    // Nonvolatile array, not touched by reset
    logic [7:0]  mem_q [256];
    deac_state_t st_q;
    deac_state_t st_d;
    logic        wr_commit;
    logic [7:0]  mem_rd;
    logic        aw_hs;
    logic        w_hs;
    logic        do_wr;
    logic        do_rd;

    // Register decode shared by read and write side
    function automatic logic known_off(input logic [7:0] off);
        known_off = (off == DEAC_OFF_DATA) || (off == DEAC_OFF_ADDR) ||
                    (off == DEAC_OFF_CTRL) || (off == DEAC_OFF_KEY) ||
                    (off == DEAC_OFF_FLAG) || (off == DEAC_OFF_STAT);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake terms

    // Each channel accepts once and holds until the response drains.
    // Ready flags are registered copies of the channel-free terms, so
    // the bus sees them straight from flip-flops with no extra latency.
    assign aw_hs = s_axi_awvalid && st_q.awready;
    assign w_hs  = s_axi_wvalid && st_q.wready;
    assign do_rd = s_axi_arvalid && st_q.arready;
    // Array read port always follows the address register
    assign mem_rd = mem_q[st_q.addr];

    // Write completes when both address and data are present
    always_comb begin
        do_wr = (st_q.aw_got || aw_hs) && (st_q.w_got || w_hs);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        logic [7:0] woff;
        logic [7:0] wbyte;
        logic       wlane;
        logic [7:0] roff;
        woff      = st_q.aw_got ? st_q.aw_addr : s_axi_awaddr;
        wbyte     = st_q.w_got ? st_q.w_byte : s_axi_wdata[7:0];
        wlane     = st_q.w_got ? st_q.w_strb[0] : s_axi_wstrb[0];
        roff      = s_axi_araddr;
        st_d      = st_q;
        wr_commit = 1'b0;

        // Response channels drain
        if (st_q.bvalid && s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (st_q.rvalid && s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end

        // Power-up timer
        // power-up hold
        if (!st_q.pwr_ok) begin
            if (st_q.pcnt >= PWRUP_CYC - 1) begin
                st_d.pwr_ok = 1'b1;
            end else begin
                st_d.pcnt = st_q.pcnt + 32'd1;
            end
        end

        // Unlock step spacing: the counter runs from each key write and
        // drops the tracker once the next step is more than one cycle later than
        // the tightest spacing the bus allows. The step itself still sees the old
        // tracker state, so a step landing on the last cycle is accepted.
        // back-to-back window
        if (st_q.unl != DEAC_UNL_IDLE) begin
            st_d.gap = st_q.gap + 4'h1;
            if (st_q.gap >= DEAC_GAP_CYC) begin
                st_d.unl = DEAC_UNL_IDLE;
            end
        end

        if (st_q.rd) begin
            st_d.data = mem_rd;
            st_d.rd   = 1'b0;
        end

        if (st_q.wr) begin
            if (st_q.wcnt >= WRITE_CYC - 1) begin
                wr_commit = 1'b1;
                st_d.wr    = 1'b0;
                st_d.done  = 1'b1;
                st_d.abort = 1'b0;
            end else begin
                st_d.wcnt = st_q.wcnt + 32'd1;
            end
        end

        // Accept write channels
        if (aw_hs) begin
            st_d.aw_got  = 1'b1;
            st_d.aw_addr = s_axi_awaddr;
        end
        if (w_hs) begin
            st_d.w_got  = 1'b1;
            st_d.w_byte = s_axi_wdata[7:0];
            st_d.w_strb = s_axi_wstrb;
        end

        // Register write effects
        if (do_wr) begin
            st_d.aw_got = 1'b0;
            st_d.w_got  = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp  = known_off(woff) ? DEAC_RESP_OKAY : DEAC_RESP_SLVERR;
            if (woff != DEAC_OFF_KEY && woff != DEAC_OFF_CTRL) begin
                st_d.unl = DEAC_UNL_IDLE;
            end
            if (wlane) begin
                unique case (woff)
                    DEAC_OFF_DATA: begin
                        st_d.data = wbyte;
                    end
                    DEAC_OFF_ADDR: st_d.addr = wbyte;
                    DEAC_OFF_KEY: begin
                        st_d.gap = 4'h0;
                        if (st_q.unl == DEAC_UNL_IDLE &&
                            wbyte == DEAC_KEY_FIRST) begin
                            st_d.unl = DEAC_UNL_GOT55;
                        end else if (st_q.unl == DEAC_UNL_GOT55 &&
                                     wbyte == DEAC_KEY_SECOND) begin
                            st_d.unl = DEAC_UNL_GOTAA;
                        end else begin
                            st_d.unl = DEAC_UNL_IDLE;
                        end
                    end
                    DEAC_OFF_CTRL: begin
                        st_d.allow = wbyte[DEAC_BIT_ALLOW];
                        st_d.abort = wbyte[DEAC_BIT_ABORT];
                        if (wbyte[DEAC_BIT_RD] && !st_q.wr) begin
                            st_d.rd = 1'b1;
                        end
                        if (wbyte[DEAC_BIT_WR] && !st_q.wr &&
                            st_q.allow && st_q.pwr_ok &&
                            st_q.unl == DEAC_UNL_GOTAA) begin
                            st_d.wr    = 1'b1;
                            st_d.wcnt  = 32'd0;
                            st_d.wdata = st_q.data;
                            st_d.waddr = st_q.addr;
                        end
                        st_d.unl = DEAC_UNL_IDLE;
                    end
                    DEAC_OFF_FLAG: begin
                        if (!wbyte[DEAC_BIT_DONE] && !wr_commit) begin
                            st_d.done = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end

        // Register reads
        if (do_rd) begin
            st_d.rvalid = 1'b1;
            st_d.rresp  = known_off(roff) ? DEAC_RESP_OKAY : DEAC_RESP_SLVERR;
            st_d.rdata  = 32'h0000_0000;
            if (roff != DEAC_OFF_KEY && roff != DEAC_OFF_CTRL) begin
                st_d.unl = DEAC_UNL_IDLE;
            end
            unique case (roff)
                DEAC_OFF_DATA: st_d.rdata[7:0] = st_q.data;
                DEAC_OFF_ADDR: st_d.rdata[7:0] = st_q.addr;
                DEAC_OFF_CTRL: st_d.rdata[3:0] = {st_q.abort, st_q.allow,
                                                  st_q.wr, st_q.rd};
                DEAC_OFF_KEY:  st_d.rdata = 32'h0000_0000;
                DEAC_OFF_FLAG: st_d.rdata[DEAC_BIT_DONE] = st_q.done;
                DEAC_OFF_STAT: begin
                    st_d.rdata[DEAC_BIT_PUT]  = !st_q.pwr_ok;
                    st_d.rdata[DEAC_BIT_BUSY] = st_q.wr;
                end
                default: ;
            endcase
        end

        // programmer port reads zero when protected
        st_d.prog_valid = prog_req;
        st_d.prog_data  = (prog_req && !protect) ? mem_q[prog_addr]
                                                 : 8'h00;

        // Ready flags follow the next channel state, so a channel
        // reopens in the cycle after its response drains
        st_d.awready = !st_d.aw_got && !st_d.bvalid;
        st_d.wready  = !st_d.w_got && !st_d.bvalid;
        st_d.arready = !st_d.rvalid;
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            // every reset clears data and address; on warm reset a write in progress sets abort
            st_q <= '0;
            // Channels are free straight out of reset
            st_q.awready <= 1'b1;
            st_q.wready  <= 1'b1;
            st_q.arready <= 1'b1;
            st_q.data <= DEAC_RST_BYTE;
            st_q.addr <= DEAC_RST_BYTE;
            st_q.abort <= st_q.wr ? 1'b1 : st_q.abort;
            // allow held over warm reset, cleared on power-up
            st_q.allow <= por_n ? st_q.allow : 1'b0;
            st_q.done  <= por_n ? st_q.done : 1'b0;
            st_q.pwr_ok <= por_n ? st_q.pwr_ok : 1'b0;
            if (!por_n) begin
                st_q.abort <= 1'b0;
            end
        end else begin
            st_q <= st_d;
        end
    end

    // The array has no reset: its contents must survive every reset.
    // A write cut short by reset before its commit cycle leaves the addressed
    // location unchanged; reset on the commit cycle itself still writes it.
    // array update at write end
    always_ff @(posedge aclk) begin
        if (wr_commit) begin
            mem_q[st_q.waddr] <= st_q.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // All outputs come straight from the state register
    assign s_axi_awready = st_q.awready;
    assign s_axi_wready  = st_q.wready;
    assign s_axi_bvalid  = st_q.bvalid;
    assign s_axi_bresp   = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid  = st_q.rvalid;
    assign s_axi_rdata   = st_q.rdata;
    assign s_axi_rresp   = st_q.rresp;
    assign prog_valid    = st_q.prog_valid;
    assign prog_data     = st_q.prog_data;

endmodule

`default_nettype wire

// ### deac_pkg.sv
package deac_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [7:0] DEAC_OFF_DATA    = 8'h00;
    localparam logic [7:0] DEAC_OFF_ADDR    = 8'h04;
    localparam logic [7:0] DEAC_OFF_CTRL    = 8'h08;
    localparam logic [7:0] DEAC_OFF_KEY     = 8'h0C;
    localparam logic [7:0] DEAC_OFF_FLAG    = 8'h10;
    localparam logic [7:0] DEAC_OFF_STAT    = 8'h14;

    // Control register bit positions
    localparam int DEAC_BIT_RD    = 0;
    localparam int DEAC_BIT_WR    = 1;
    localparam int DEAC_BIT_ALLOW = 2;
    localparam int DEAC_BIT_ABORT = 3;
    // Flag register bit position of write_done_flag
    localparam int DEAC_BIT_DONE  = 7;
    // Status register bit positions
    localparam int DEAC_BIT_PUT   = 0;
    localparam int DEAC_BIT_BUSY  = 1;

    // Reset values
    localparam logic [7:0] DEAC_RST_BYTE = 8'h00;

    // Unlock keys
    localparam logic [7:0] DEAC_KEY_FIRST  = 8'h55;
    localparam logic [7:0] DEAC_KEY_SECOND = 8'hAA;

    // Cycles allowed between successive unlock steps (back to back);
    // bus writes can land no closer than two cycles apart
    localparam logic [3:0] DEAC_GAP_CYC = 4'h2;

    // Self-timed write length and power-up timer
    localparam int DEAC_CLK_MHZ        = 50;
    localparam int DEAC_WRITE_US       = 5000;
    localparam int DEAC_WRITE_CYC      = DEAC_WRITE_US * DEAC_CLK_MHZ;
    localparam int DEAC_PWRUP_MS       = 64;
    localparam int DEAC_PWRUP_CYC      = DEAC_PWRUP_MS * 1000 * DEAC_CLK_MHZ;

    // AXI responses
    localparam logic [1:0] DEAC_RESP_OKAY   = 2'b00;
    localparam logic [1:0] DEAC_RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        DEAC_UNL_IDLE,
        DEAC_UNL_GOT55,
        DEAC_UNL_GOTAA
    } deac_unl_t;

    // Whole state of the controller
    typedef struct packed {
        logic [7:0]  data;
        logic [7:0]  addr;
        logic        rd;
        logic        wr;
        logic        allow;
        logic        abort;
        logic        done;
        deac_unl_t   unl;
        logic [3:0]  gap;
        logic [31:0] wcnt;
        logic [31:0] pcnt;
        logic        pwr_ok;
        logic [7:0]  wdata;
        logic [7:0]  waddr;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  aw_addr;
        logic [7:0]  w_byte;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        prog_valid;
        logic [7:0]  prog_data;
        logic        awready;
        logic        wready;
        logic        arready;
    } deac_state_t;

endpackage

// ### deac_chk.sv
`timescale 1ns/1ps
`default_nettype none
module deac_chk
    import deac_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        protect,
    input wire logic        prog_req,
    input wire logic        prog_valid,
    input wire logic [7:0]  prog_data,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Taken write and read requests
    sequence wr_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_s;
        s_axi_arvalid && s_axi_arready;
    endsequence
    ////////////////////////////////////////////
    // Response timing and channel blocking
    b_answer_a: assert property (wr_s |=> s_axi_bvalid)
        else $error("write response late");
    r_answer_a: assert property (rd_s |=> s_axi_rvalid)
        else $error("read response late");
    b_drain_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not released");
    r_drain_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response not released");
    b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    r_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while response pending");
    // Read data of key port and control register
    key_zero_a: assert property (
        rd_s ##0 (s_axi_araddr == DEAC_OFF_KEY) |=> s_axi_rdata == 32'h0000_0000)
        else $error("key port read not zero");
    ctrl_upper_a: assert property (
        rd_s ##0 (s_axi_araddr == DEAC_OFF_CTRL) |=> s_axi_rdata[31:4] == 28'h0)
        else $error("control upper bits not zero");
    // Programmer port under protection
    prog_zero_a: assert property (
        prog_req && protect |=> prog_valid && prog_data == 8'h00)
        else $error("protected programmer read not zero");
endmodule
bind deac_ctrl deac_chk deac_chk_inst (.*);
`default_nettype wire

// ### deac_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module deac_ctrl_test
    import deac_pkg::*;
;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        por_n = 1'b0;
    logic        protect = 1'b0;
    logic        prog_req = 1'b0;
    logic [7:0]  prog_addr = 8'h00;
    logic        prog_valid;
    logic [7:0]  prog_data;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic [2:0]  s_axi_awprot = 3'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b1;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic [2:0]  s_axi_arprot = 3'h0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b1;
    int          miscompares = 0;
    int          compares = 0;

    // Short write and power-up counts
    deac_ctrl #(.WRITE_CYC(20), .PWRUP_CYC(50)) deac_ctrl_inst (.*);

    // Clock of 20 ns
    always #10 aclk = ~aclk;

    ////////////////////////////////////////////
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic hang();
        chk("wait bound", 32'h0000_0001, 32'h0000_0000);
        report_and_stop();
    endtask
    // Bus write: address and data offered together
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er = 2'b00);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        if (n == 50) hang();
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    // Bus read
    task automatic rd(logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        if (n == 50) hang();
        d = s_axi_rdata;
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask
    task automatic rc(string nm, logic [7:0] a, logic [31:0] e);
        logic [31:0] d;
        rd(a, d, DEAC_RESP_OKAY);
        chk(nm, e, d);
    endtask
    task automatic wait_bit(logic [7:0] a, int b, logic v);
        logic [31:0] d;
        int n;
        for (n = 0; n < 100; n++) begin
            rd(a, d, DEAC_RESP_OKAY);
            if (d[b] === v) break;
        end
        if (n == 100) hang();
    endtask
    // Load, enable, unlock and start one byte write
    task automatic ee_write(logic [7:0] a, logic [7:0] v);
        wr(DEAC_OFF_DATA, {24'h0, v});
        wr(DEAC_OFF_ADDR, {24'h0, a});
        wr(DEAC_OFF_CTRL, 32'h0000_0004);
        wr(DEAC_OFF_KEY, {24'h0, DEAC_KEY_FIRST});
        wr(DEAC_OFF_KEY, {24'h0, DEAC_KEY_SECOND});
        wr(DEAC_OFF_CTRL, 32'h0000_0006);
    endtask
    task automatic ee_read(logic [7:0] a, logic [7:0] e);
        wr(DEAC_OFF_ADDR, {24'h0, a});
        wr(DEAC_OFF_CTRL, 32'h0000_0001);
        rc("read data", DEAC_OFF_DATA, {24'h0, e});
    endtask
    // Broken unlock attempt, write trigger must stay low
    task automatic try_seq(logic [7:0] k1, logic [7:0] k2, int gap, bit mid);
        logic [31:0] d;
        wr(DEAC_OFF_CTRL, 32'h0000_0004);
        wr(DEAC_OFF_KEY, {24'h0, k1});
        repeat (gap) @(posedge aclk);
        if (mid) rd(DEAC_OFF_DATA, d, DEAC_RESP_OKAY);
        wr(DEAC_OFF_KEY, {24'h0, k2});
        wr(DEAC_OFF_CTRL, 32'h0000_0006);
        rc("refused start", DEAC_OFF_CTRL, 32'h0000_0004);
    endtask

    ////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] d;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge aclk);
        rc("data reset", DEAC_OFF_DATA, 32'h0000_0000);
        rc("addr reset", DEAC_OFF_ADDR, 32'h0000_0000);
        rc("ctrl reset", DEAC_OFF_CTRL, 32'h0000_0000);
        rc("key read", DEAC_OFF_KEY, 32'h0000_0000);
        rc("powerup run", DEAC_OFF_STAT, 32'h0000_0001);
        ee_write(8'h3C, 8'hA5);
        rc("powerup block", DEAC_OFF_CTRL, 32'h0000_0004);
        wait_bit(DEAC_OFF_STAT, DEAC_BIT_PUT, 1'b0);
        wr(8'h20, 32'h0000_0001, DEAC_RESP_SLVERR);
        rd(8'h20, d, DEAC_RESP_SLVERR);
        wr(DEAC_OFF_CTRL, 32'h0000_0000);
        wr(DEAC_OFF_KEY, {24'h0, DEAC_KEY_FIRST});
        wr(DEAC_OFF_KEY, {24'h0, DEAC_KEY_SECOND});
        wr(DEAC_OFF_CTRL, 32'h0000_0002);
        rc("no allow", DEAC_OFF_CTRL, 32'h0000_0000);
        try_seq(DEAC_KEY_SECOND, DEAC_KEY_FIRST, 0, 1'b0);
        try_seq(DEAC_KEY_FIRST, DEAC_KEY_FIRST, 0, 1'b0);
        try_seq(DEAC_KEY_FIRST, DEAC_KEY_SECOND, 4, 1'b0);
        try_seq(DEAC_KEY_FIRST, DEAC_KEY_SECOND, 0, 1'b1);
        ee_write(8'h3C, 8'hA5);
        rc("write busy", DEAC_OFF_CTRL, 32'h0000_0006);
        wr(DEAC_OFF_CTRL, 32'h0000_0000);
        rc("allow off", DEAC_OFF_CTRL, 32'h0000_0002);
        wait_bit(DEAC_OFF_CTRL, DEAC_BIT_WR, 1'b0);
        rc("no abort", DEAC_OFF_CTRL, 32'h0000_0000);
        rc("done set", DEAC_OFF_FLAG, 32'h0000_0080);
        rc("done held", DEAC_OFF_FLAG, 32'h0000_0080);
        wr(DEAC_OFF_FLAG, 32'h0000_0000);
        rc("done clear", DEAC_OFF_FLAG, 32'h0000_0000);
        ee_read(8'h3C, 8'hA5);
        rc("rd cleared", DEAC_OFF_CTRL, 32'h0000_0000);
        ee_write(8'h3C, 8'h5A);
        wait_bit(DEAC_OFF_CTRL, DEAC_BIT_WR, 1'b0);
        ee_write(8'hFF, 8'hC3);
        wait_bit(DEAC_OFF_CTRL, DEAC_BIT_WR, 1'b0);
        ee_read(8'h3C, 8'h5A);
        wr(DEAC_OFF_ADDR, 32'h0000_0011);
        rc("data kept", DEAC_OFF_DATA, 32'h0000_005A);
        ee_read(8'hFF, 8'hC3);
        // Programmer port with and without protection
        protect <= 1'b1;
        prog_addr <= 8'hFF;
        prog_req <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("prog zero", 32'h0000_0000, {24'h0, prog_data});
        protect <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("prog data", 32'h0000_01C3, {23'h0, prog_valid, prog_data});
        prog_req <= 1'b0;
        // Reset cuts a write short
        wr(DEAC_OFF_FLAG, 32'h0000_0000);
        ee_write(8'h10, 8'h77);
        repeat (3) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc("abort set", DEAC_OFF_CTRL, 32'h0000_000C);
        rc("data cut", DEAC_OFF_DATA, 32'h0000_0000);
        rc("addr cut", DEAC_OFF_ADDR, 32'h0000_0000);
        rc("no done", DEAC_OFF_FLAG, 32'h0000_0000);
        wr(DEAC_OFF_CTRL, 32'hFFFF_FFF4);
        rc("upper zero", DEAC_OFF_CTRL, 32'h0000_0004);
        report_and_stop();
    end
endmodule
`default_nettype wire
